// ==== rtl/gpa_port.sv ====
// Five-bit port with direction control and analog pin selection, APB slave.
// Assumes pins arrive unsynchronised and the pad resolves out/oe itself.
// What this block does
// - Five-bit output latch, one bit per pin
// - Pin 4 Schmitt input, open-drain low-only output
// - Pins 0-3 TTL input, push-pull output
// - Direction bit one releases pin driver
// - Direction bit zero drives latch onto pin
// - Reads return pins, writes load latch
// - Bit-set, bit-clear and lane-off data writes are read-modify-write of pin levels
// - Pin 4 input feeds timer external clock
// - Two config bits choose analog or digital pins
// - Reset leaves analog pins selected, reading zero
// - Direction still rules drivers on analog pins
// - Power reset clears latch 4:0; any reset sets direction all ones
// - Unimplemented register bits read zero
// - Pin taken by converter loses digital input, keeps its driver
module gpa_port (
    input  wire logic        pclk,
    input  wire logic        presetn,           // Power-on and brown-out reset
    input  wire logic        other_reset,       // Non-power reset, one-cycle pulse
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [4:0]  pin_in,            // Pad levels after input buffers
    output logic      [4:0]  pin_out,
    output logic      [4:0]  pin_oe,
    output logic             timer_ext_clk_in,  // Pin 4 toward the timer
    output logic      [3:0]  analog_en,         // Pins handed to the converter
    output logic             vref_ext_sel       // Pin 3 used as reference
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [4:0]  latch_reg;      // Port data latch
    logic [4:0]  latch_next;
    logic [4:0]  dir_reg;        // One releases the driver
    logic [4:0]  dir_next;
    logic [1:0]  cfg_reg;        // Analog selection
    logic [1:0]  cfg_next;
    logic [31:0] prdata_reg;     // Read data captured in setup
    logic        pready_reg;     // High in every access phase
    logic        pslverr_reg;    // Unmapped address
    logic        tmr_clk_reg;    // Timer clock copy
    logic [3:0]  ana_en_reg;
    logic        vref_reg;
    logic [4:0]  pins_sync;      // Pins after two flops

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser; buffer thresholds live in the pad cells
    gpa_sync #(
        .WIDTH    (gpa_pkg::PORT_W)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_in),
        .sync_out (pins_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Analog selection decode
    logic [3:0] ana_mask_w;      // Pins not available as digital
    logic       ext_ref_w;       // Pin 3 as reference
    assign ana_mask_w = (cfg_reg == gpa_pkg::CFG_ALL_ANA) ? gpa_pkg::ANA_MASK_ALL :
                        (cfg_reg == gpa_pkg::CFG_EXT_REF) ? gpa_pkg::ANA_MASK_ALL :
                        (cfg_reg == gpa_pkg::CFG_TWO_ANA) ? gpa_pkg::ANA_MASK_TWO :
                                                            gpa_pkg::ANA_MASK_NONE;
    assign ext_ref_w  = (cfg_reg == gpa_pkg::CFG_EXT_REF);

    // Converter inputs exclude the reference pin
    logic [3:0] ana_in_w;
    assign ana_in_w = ext_ref_w ? gpa_pkg::ANA_MASK_REF : ana_mask_w;

    // Digital view of the pins; analog pins read as zero
    logic [4:0] pin_read_w;
    assign pin_read_w = {pins_sync[4], pins_sync[3:0] & ~ana_mask_w};

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic setup_w;               // First cycle of a transfer
    logic acc_w;                 // Completing access
    logic wr_w;                  // Completing write
    logic lane0_w;               // Low byte written
    logic hit_data_w;
    logic hit_dir_w;
    logic hit_cfg_w;
    logic hit_set_w;
    logic hit_clr_w;
    logic hit_any_w;
    assign setup_w    = psel & ~penable;
    assign acc_w      = psel & penable & pready_reg;
    assign wr_w       = acc_w & pwrite;
    assign lane0_w    = pstrb[0];
    assign hit_data_w = (paddr == gpa_pkg::ADDR_DATA);
    assign hit_dir_w  = (paddr == gpa_pkg::ADDR_DIR);
    assign hit_cfg_w  = (paddr == gpa_pkg::ADDR_CFG);
    assign hit_set_w  = (paddr == gpa_pkg::ADDR_SET);
    assign hit_clr_w  = (paddr == gpa_pkg::ADDR_CLR);
    assign hit_any_w  = hit_data_w | hit_dir_w | hit_cfg_w | hit_set_w | hit_clr_w;

    // Read mux, upper bits zero
    logic [31:0] rd_mux_w;
    assign rd_mux_w = hit_data_w ? {27'h0000000, pin_read_w} :
                      hit_dir_w  ? {27'h0000000, dir_reg} :
                      hit_cfg_w  ? {30'h0000000, cfg_reg} :
                                   32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Next-state for the latch: set, clear and lane-off data writes start from the pin levels
    // A write with lane 0 off still reloads the latch from the pins,
    // the same way a bit operation on the port would.
    always_comb begin
        latch_next = latch_reg;
        if (wr_w && hit_data_w) begin
            latch_next = lane0_w ? pwdata[4:0] : pin_read_w;
        end else if (wr_w && hit_set_w) begin
            latch_next = pin_read_w | (lane0_w ? pwdata[4:0] : 5'h00);
        end else if (wr_w && hit_clr_w) begin
            latch_next = pin_read_w & ~(lane0_w ? pwdata[4:0] : 5'h00);
        end
    end

    // Direction and config: other resets win over a write
    always_comb begin
        dir_next = dir_reg;
        cfg_next = cfg_reg;
        if (other_reset) begin
            dir_next = gpa_pkg::DIR_RST;
            cfg_next = gpa_pkg::CFG_RST;
        end else if (wr_w && lane0_w) begin
            if (hit_dir_w) begin
                dir_next = pwdata[4:0];
            end
            if (hit_cfg_w) begin
                cfg_next = pwdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch keeps its value on other resets; only power reset clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= gpa_pkg::LATCH_RST;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_reg <= gpa_pkg::DIR_RST;
            cfg_reg <= gpa_pkg::CFG_RST;
        end else begin
            dir_reg <= dir_next;
            cfg_reg <= cfg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer: captured in setup, shown in the single access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup_w;
            pslverr_reg <= setup_w & ~hit_any_w;
            if (setup_w) begin
                prdata_reg <= pwrite ? 32'h00000000 : rd_mux_w;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Side outputs toward the timer and the converter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_clk_reg <= 1'b0;
            ana_en_reg  <= gpa_pkg::ANA_MASK_ALL;
            vref_reg    <= 1'b0;
        end else begin
            tmr_clk_reg <= pins_sync[gpa_pkg::OD_BIT];
            ana_en_reg  <= ana_in_w;
            vref_reg    <= ext_ref_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers; direction governs even analog pins
    // Software must hold direction set on analog pins, else the driver
    // fights the analog source; hardware does not override it.
    genvar g;
    generate
        for (g = 0; g < gpa_pkg::PORT_W; g++) begin : g_pad
            gpa_pad #(
                .OPEN_DRAIN (g == gpa_pkg::OD_BIT)
            ) u_pad (
                .pclk       (pclk),
                .presetn    (presetn),
                .latch_bit  (latch_reg[g]),
                .dir_bit    (dir_reg[g]),
                .pad_out    (pin_out[g]),
                .pad_oe     (pin_oe[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Output assignments
    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;
    assign timer_ext_clk_in = tmr_clk_reg;
    assign analog_en        = ana_en_reg;
    assign vref_ext_sel     = vref_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic wr_data_w;             // Completing write to the data latch
    assign wr_data_w = wr_w & hit_data_w;

    // Lane-off write reloads the latch from the pins
    property p_rmw_reload;
        @(posedge pclk) disable iff (!presetn)
        (wr_data_w && !lane0_w) |=> (latch_reg == $past(pin_read_w));
    endproperty
    a_rmw_reload: assert property (p_rmw_reload)
        else $error("latch not reloaded from pins");

    // Released direction never drives one cycle on
    property p_dir_release;
        @(posedge pclk) disable iff (!presetn)
        (dir_reg != 5'h00) |-> ##1 ((pin_oe & $past(dir_reg)) == 5'h00);
    endproperty
    a_dir_release: assert property (p_dir_release)
        else $error("driver enabled on input pin");

    // Push-pull output pins 0-3 carry the latch
    property p_drive_latch;
        @(posedge pclk) disable iff (!presetn)
        (dir_reg[3:0] == 4'h0) |=> (pin_oe[3:0] == 4'hF) && (pin_out[3:0] == $past(latch_reg[3:0]));
    endproperty
    a_drive_latch: assert property (p_drive_latch)
        else $error("push-pull pins not driving latch");

    // Open-drain pin only ever pulls low
    property p_open_drain;
        @(posedge pclk) disable iff (!presetn)
        (!dir_reg[4] && latch_reg[4]) |=> !pin_oe[4] && !pin_out[4];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high");

    // Data read returns the synchronised pins, upper bits zero
    property p_read_pins;
        @(posedge pclk) disable iff (!presetn)
        (setup_w && !pwrite && hit_data_w) |=> pready && prdata == {27'h0000000, $past(pin_read_w)};
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("port read mismatch");

    // Non-power reset restores direction and keeps the latch
    property p_other_reset;
        @(posedge pclk) disable iff (!presetn)
        other_reset |=> (dir_reg == gpa_pkg::DIR_RST) && (latch_reg == $past(latch_reg));
    endproperty
    a_other_reset: assert property (p_other_reset)
        else $error("other reset handled wrongly");

    // Full analog selection hides pins 0..3 from reads
    property p_analog_zero;
        @(posedge pclk) disable iff (!presetn)
        (cfg_reg == gpa_pkg::CFG_ALL_ANA && setup_w && !pwrite && hit_data_w) |=> (prdata[3:0] == 4'h0);
    endproperty
    a_analog_zero: assert property (p_analog_zero)
        else $error("analog pin read nonzero");

    // Timer clock follows the synchronised pin one cycle later
    property p_timer_clk;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> timer_ext_clk_in == $past(pins_sync[4]);
    endproperty
    a_timer_clk: assert property (p_timer_clk)
        else $error("timer clock not following pin");

    // Analog pin still driven when its direction is clear
    property p_analog_dir;
        @(posedge pclk) disable iff (!presetn)
        (ana_mask_w[0] && !dir_reg[0]) |=> pin_oe[0];
    endproperty
    a_analog_dir: assert property (p_analog_dir)
        else $error("direction ignored on analog pin");

    // Unmapped address answers with an error
    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (setup_w && !hit_any_w) |=> pready && pslverr && (prdata[31:5] == 27'h0000000);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    // Main scenarios
    c_read_data:  cover property (@(posedge pclk) disable iff (!presetn) acc_w && !pwrite && hit_data_w);
    c_write_rmw:  cover property (@(posedge pclk) disable iff (!presetn) wr_data_w && !lane0_w);
    c_bit_set:    cover property (@(posedge pclk) disable iff (!presetn) wr_w && hit_set_w);
    c_other_rst:  cover property (@(posedge pclk) disable iff (!presetn) other_reset);

endmodule

// ==== rtl/gpa_pkg.sv ====
// Constants for the five-bit port with analog pin selection.
// Assumes a 32-bit APB slave with a 12-bit byte address and one clock.
package gpa_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_DATA      = 8'h05;  // Port data latch
    localparam logic [7:0]  IDX_DIR       = 8'h85;  // Port direction
    localparam logic [7:0]  IDX_CFG       = 8'h9F;  // Analog pin config
    localparam logic [7:0]  IDX_SET       = 8'hA0;  // Bit-set of data latch
    localparam logic [7:0]  IDX_CLR       = 8'hA1;  // Bit-clear of data latch
    localparam logic [11:0] ADDR_DATA     = {2'b00, IDX_DATA, 2'b00};
    localparam logic [11:0] ADDR_DIR      = {2'b00, IDX_DIR, 2'b00};
    localparam logic [11:0] ADDR_CFG      = {2'b00, IDX_CFG, 2'b00};
    localparam logic [11:0] ADDR_SET      = {2'b00, IDX_SET, 2'b00};
    localparam logic [11:0] ADDR_CLR      = {2'b00, IDX_CLR, 2'b00};

    ////////////////////////////////////////////////////////////////////////
    // Field layout
    localparam int          PORT_W        = 5;      // Pins on the port
    localparam int          ANA_W         = 4;      // Analog-capable pins
    localparam int          CFG_W         = 2;      // Config field width
    localparam int          OD_BIT        = 4;      // Open-drain, timer clock pin

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [4:0]  LATCH_RST     = 5'h00;  // Bit 4 unknown, forced low
    localparam logic [4:0]  DIR_RST       = 5'h1F;  // All inputs
    localparam logic [1:0]  CFG_RST       = 2'h0;   // All analog

    ////////////////////////////////////////////////////////////////////////
    // Analog selections
    localparam logic [1:0]  CFG_ALL_ANA   = 2'h0;   // Pins 0..3 analog
    localparam logic [1:0]  CFG_EXT_REF   = 2'h1;   // Pins 0..2 analog, pin 3 reference
    localparam logic [1:0]  CFG_TWO_ANA   = 2'h2;   // Pins 0..1 analog
    localparam logic [1:0]  CFG_ALL_DIG   = 2'h3;   // All digital
    localparam logic [3:0]  ANA_MASK_ALL  = 4'hF;   // Pins lost to the converter
    localparam logic [3:0]  ANA_MASK_REF  = 4'h7;
    localparam logic [3:0]  ANA_MASK_TWO  = 4'h3;
    localparam logic [3:0]  ANA_MASK_NONE = 4'h0;

endpackage

// ==== rtl/gpa_sync.sv ====
// Two-stage synchroniser for a bus of independent levels.
// Assumes inputs change without regard to pclk; each bit is a level.
module gpa_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;  // Read only by the second stage

    ////////////////////////////////////////////////////////////////////////
    // Both stages clear on reset; metastability settles in stage one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule

// ==== rtl/gpa_pad.sv ====
// Registered driver control for one port pin.
// Assumes the pad wire is resolved outside from out and enable.
module gpa_pad #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic latch_bit,
    input  wire logic dir_bit,
    output logic      pad_out,
    output logic      pad_oe
);

    logic out_next;  // Level to drive
    logic oe_next;   // Drive enable

    // Open drain only pulls low; push-pull follows the latch
    assign out_next = OPEN_DRAIN ? 1'b0 : latch_bit;
    assign oe_next  = ~dir_bit & (OPEN_DRAIN ? ~latch_bit : 1'b1);

    ////////////////////////////////////////////////////////////////////////
    // Driver released during reset so no pin fights the board
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else begin
            pad_out <= out_next;
            pad_oe  <= oe_next;
        end
    end

endmodule

// ==== testbench/gpa_pin_model.sv ====
// Board-side model of the five port pins and whatever drives them from outside.
// Assumes the port gives registered pin_out/pin_oe and the bench sets outside levels.
module gpa_pin_model (
    input  wire logic       pclk,
    input  wire logic [4:0] pin_out,  // Port drive level
    input  wire logic [4:0] pin_oe,   // Port drives the pin
    input  wire logic [4:0] ext_val,  // Level from outside circuitry
    input  wire logic [4:0] ext_en,   // Outside circuitry drives the pin
    output logic      [4:0] pin_in    // Resolved pad level
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] last_reg = 5'h00;     // Pad level at the previous edge

    ////////////////////////////////////////////////////////////////////////
    // Remember the pad levels so floating pins can wander
    always @(posedge pclk) begin
        last_reg <= pin_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // Resolve each pad; a floating push-pull pin has no pull, so it never
    // keeps its old level and a stale read cannot pass by luck
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (pin_oe[i] && ext_en[i]) begin
                pin_in[i] = 1'bx;              // Two drivers fight
            end else if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];        // Outside level wins
            end else if (i == 4) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = ~last_reg[i];      // Floating, no pull
            end
        end
    end
endmodule

// ==== testbench/gpa_port_tb.sv ====
// Self-checking bench for the five-bit port: APB tasks plus pin scenarios.
// Assumes zero-wait APB answers and a pin model resolving the pads.
module gpa_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end

    logic        pclk = 1'b0;         // 100 MHz clock
    logic        presetn = 1'b0;      // Power reset, active low
    logic        other_reset = 1'b0;  // Non-power reset pulse
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  pin_in;
    logic [4:0]  pin_out;
    logic [4:0]  pin_oe;
    logic        timer_ext_clk_in;
    logic [3:0]  analog_en;
    logic        vref_ext_sel;
    logic [4:0]  ext_val = 5'h1F;     // Outside pin levels
    logic [4:0]  ext_en = 5'h1F;      // Outside drivers on
    logic [31:0] rdv;                 // Last read data
    logic        erv;                 // Last error flag
    int          errors = 0;
    int          n_tests = 0;
    int          cyc = 0;             // Timeout counter
    logic [3:0]  masks [4] = '{gpa_pkg::ANA_MASK_ALL, gpa_pkg::ANA_MASK_REF,
                               gpa_pkg::ANA_MASK_TWO, gpa_pkg::ANA_MASK_NONE};

    gpa_port dut_u (.pclk(pclk), .presetn(presetn), .other_reset(other_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .timer_ext_clk_in(timer_ext_clk_in), .analog_en(analog_en),
        .vref_ext_sel(vref_ext_sel));

    gpa_pin_model pins_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; a run well under 1000 cycles is expected
    initial begin
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus tasks; entered just after a rising edge, leave just after one
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Hold the request until pready is seen at an edge
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so the next call never reassigns psel in this step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 4'hF);
        `CHK(rdv, x)
        `CHK(erv, 1'b0)
    endtask

    task automatic complete_run();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(6);
        presetn <= 1'b1;
        tick(1);
        // Reset state: all inputs, all analog
        `CHK(pin_oe, 5'h00)
        `CHK(analog_en, 4'hF)
        rd(gpa_pkg::ADDR_DIR, 32'h1F);
        rd(gpa_pkg::ADDR_CFG, 32'h0);
        rd(gpa_pkg::ADDR_DATA, 32'h10);
        // Every analog selection, direction left all ones
        ext_val <= 5'h1D;
        for (int i = 0; i < 4; i++) begin
            wr(gpa_pkg::ADDR_CFG, 32'(i), 4'hF);
            tick(2);
            `CHK(analog_en, masks[i])
            `CHK(vref_ext_sel, (i == 1))
            // Reference pin is lost to digital reads as well
            rd(gpa_pkg::ADDR_DATA, 32'({5'h1D & ~{1'b0, ((i == 1) ? gpa_pkg::ANA_MASK_ALL : masks[i])}}));
        end
        // Upper bits read zero
        wr(gpa_pkg::ADDR_CFG, 32'hFFFFFFFF, 4'hF);
        rd(gpa_pkg::ADDR_CFG, 32'h3);
        wr(gpa_pkg::ADDR_DIR, 32'hFFFFFFFF, 4'hF);
        rd(gpa_pkg::ADDR_DIR, 32'h1F);
        // Latch reloads from pin levels, then bit-set merges on pins
        ext_val <= 5'h0C;
        tick(3);
        wr(gpa_pkg::ADDR_DATA, 32'h13, 4'h0);
        wr(gpa_pkg::ADDR_SET, 32'h01, 4'hF);
        ext_en <= 5'h00;
        wr(gpa_pkg::ADDR_DIR, 32'h0, 4'hF);
        tick(2);
        `CHK(pin_oe, 5'h1F)
        `CHK(pin_out, 5'h0D)
        tick(2);
        rd(gpa_pkg::ADDR_DATA, 32'h0D);
        // Open drain: latch one releases the pin, pull-up reads high
        wr(gpa_pkg::ADDR_DATA, 32'h12, 4'hF);
        tick(2);
        `CHK(pin_oe, 5'h0F)
        `CHK(pin_out, 5'h02)
        tick(2);
        rd(gpa_pkg::ADDR_DATA, 32'h12);
        // Analog pins still driven when direction is zero
        wr(gpa_pkg::ADDR_CFG, 32'h0, 4'hF);
        tick(2);
        `CHK(pin_oe, 5'h0F)
        rd(gpa_pkg::ADDR_DATA, 32'h10);
        wr(gpa_pkg::ADDR_CFG, 32'h3, 4'hF);
        wr(gpa_pkg::ADDR_CLR, 32'h02, 4'hF);
        tick(2);
        `CHK(pin_out, 5'h00)
        // Pin 4 toward the timer through the synchroniser
        wr(gpa_pkg::ADDR_DIR, 32'h1F, 4'hF);
        ext_en <= 5'h1F;
        ext_val <= 5'h00;
        tick(4);
        `CHK(timer_ext_clk_in, 1'b0)
        ext_val <= 5'h10;
        tick(4);
        `CHK(timer_ext_clk_in, 1'b1)
        rd(gpa_pkg::ADDR_DATA, 32'h10);
        // Unmapped address answers with an error and zero
        apb(1'b0, 12'h004, 32'h0, 4'hF);
        `CHK(erv, 1'b1)
        `CHK(rdv, 32'h0)
        // Non-power reset keeps the latch, restores direction and config
        ext_en <= 5'h00;
        wr(gpa_pkg::ADDR_DATA, 32'h0F, 4'hF);
        other_reset <= 1'b1;
        tick(1);
        other_reset <= 1'b0;
        rd(gpa_pkg::ADDR_DIR, 32'h1F);
        rd(gpa_pkg::ADDR_CFG, 32'h0);
        wr(gpa_pkg::ADDR_DIR, 32'h0, 4'hF);
        tick(2);
        `CHK(pin_out, 5'h0F)
        // Power reset mid-run clears the latch
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(1);
        wr(gpa_pkg::ADDR_DIR, 32'h0, 4'hF);
        tick(2);
        `CHK(pin_out, 5'h00)
        `CHK(pin_oe, 5'h1F)
        complete_run();
    end
endmodule
